// ===== hdl/sebas_consts.svh
// Purpose: constants for the servo enable / brake / alarm sequencer
// Assumes: 250 MHz clock, 1 ms tick
// Notes:   times in their own unit, cycle counts derived
`ifndef SEBAS_CONSTS_SVH
`define SEBAS_CONSTS_SVH
`define SEBAS_CLK_MHZ         250
`define SEBAS_TICK_US         1000
`define SEBAS_TICK_CYC        (`SEBAS_TICK_US * `SEBAS_CLK_MHZ)
`define SEBAS_UNIT_10MS       16'h000a
`define SEBAS_ON_DLY_RST      16'h0000
`define SEBAS_ON_DLY_MAX      16'h07d0
`define SEBAS_OFF_DLY_RST     16'h0000
`define SEBAS_OFF_DLY_MAX     16'h01f4
`define SEBAS_SPD_LVL_RST     16'h0064
`define SEBAS_SPD_LVL_MIN     16'h000a
`define SEBAS_SPD_LVL_MAX     16'h0064
`define SEBAS_TMO_RST         16'h0032
`define SEBAS_TMO_MIN         16'h000a
`define SEBAS_TMO_MAX         16'h0064
`define SEBAS_MAX_SPEED_RST   16'h0bb8
// register offsets (word index)
`define SEBAS_REG_ON_DLY      4'h0
`define SEBAS_REG_OFF_DLY     4'h1
`define SEBAS_REG_SPD_LVL     4'h2
`define SEBAS_REG_TMO         4'h3
`define SEBAS_REG_CTRL        4'h4
`define SEBAS_REG_STATUS      4'h5
`define SEBAS_REG_IRQ_STAT    4'h6
`define SEBAS_REG_IRQ_EN      4'h7
`define SEBAS_REG_IRQ_CLR     4'h8
`define SEBAS_REG_MAX_SPEED   4'h9
// ctrl fields
`define SEBAS_CTRL_SRC        0
`define SEBAS_CTRL_PANEL_CLR  1
// interrupt event bits
`define SEBAS_EV_ALARM        0
`define SEBAS_EV_ENERGIZE     1
`define SEBAS_EV_BRAKE        2
`define SEBAS_EV_OFF          3
`define SEBAS_EV_W            4
`endif

// ===== hdl/sebas_pkg.sv
// Purpose: types for the servo enable / brake / alarm sequencer
// Assumes: constants come from sebas_consts.svh
// Notes:   one-hot sequencer states
package sebas_pkg;
  typedef enum logic [4:0]
  {
    SEBAS_OFF      = 5'b00001, // motor not driven, brake applied
    SEBAS_ON_WAIT  = 5'b00010, // enable seen, waiting on-delay
    SEBAS_RUN      = 5'b00100, // motor driven, brake released
    SEBAS_STOP_RUN = 5'b01000, // servo off while rotating
    SEBAS_HOLD     = 5'b10000  // brake applied, drive held
  } sebas_state_type;
endpackage : sebas_pkg

// ===== hdl/sebas_seq.sv
// Purpose: servo enable, holding brake interlock and alarm sequencer
// Assumes: inputs synchronous to clk; speed is rpm magnitude
// Notes:   registers over Avalon-MM, one read-wait cycle
//
// Contract
// RULE1 - after enable, wait programmable 0-2000 ms before energizing motor
// RULE2 - at standstill, brake applied, then hold drive off-delay x10 ms
// RULE3 - running-brake speed threshold in rpm, 10-100, default 100
// RULE4 - running-brake timeout in 10 ms units, 10-100, default 50
// RULE5 - servo off while rotating: apply brake when speed below threshold
// RULE6 - servo off while rotating: apply brake also when timeout expires
// RULE7 - threshold above maximum motor speed uses maximum motor speed
// RULE8 - running-brake timing applies to enable deassert and to alarm
// RULE9 - alarm removes motor drive immediately, no brake delay
// RULE10 - alarm output low when normal, high in alarm state
// RULE11 - alarm clear input low clears alarm; high leaves it unchanged
// RULE12 - alarm state cleared by control power removal, i.e. reset
// RULE13 - operator panel can also clear the alarm state
// RULE14 - enable low means servo on, high forces servo off
// RULE15 - enable source 1 ignores the input, servo always on
// RULE16 - host should use references, not enable, to start and stop
// RULE17 - brake output low releases brake, high applies it
// RULE18 - servo off on enable deassert, alarm, or power removal
// RULE19 - delays counted on a 1 ms tick, 10 ms settings times ten
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ns
`include "sebas_consts.svh"
module sebas_seq
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  // drive side
  input  wire logic        servo_enable_n,
  input  wire logic        alarm_detect,
  input  wire logic [15:0] motor_speed,
  input  wire logic        alarm_clear_in,
  input  wire logic        panel_clear,
  output logic             motor_energize,
  output logic             brake_interlock_out,
  output logic             alarm_out,
  output logic             irq
);

  //--------------------------------------------------------------------
  // state
  //--------------------------------------------------------------------
  typedef struct packed
  {
    // sequencer and its timers
    sebas_pkg::sebas_state_type     st;
    logic [17:0]                    tick_cnt;
    logic [15:0]                    ms_cnt;
    logic [15:0]                    stop_cnt;
    // settings
    logic [15:0]                    servo_on_delay;
    logic [15:0]                    brake_to_off_delay;
    logic [15:0]                    running_brake_speed_level;
    logic [15:0]                    running_brake_timeout;
    logic [15:0]                    max_speed;
    logic                           enable_source_select;
    // alarm latch and interrupt state
    logic                           alarm;
    logic [`SEBAS_EV_W-1:0]         irq_stat;
    logic [`SEBAS_EV_W-1:0]         irq_en;
    // bus handshake
    logic                           rd_pend;
    // registered outputs
    logic [31:0]                    readdata;
    logic                           waitrequest;
    logic                           motor_energize;
    logic                           brake_interlock_out;
    logic                           alarm_out;
    logic                           irq;
  } sebas_regs_type;

  sebas_regs_type r;
  sebas_regs_type next_r;

  //--------------------------------------------------------------------
  // helpers
  //--------------------------------------------------------------------
  // clamp a written value into a setting range
  function automatic logic [15:0] sebas_clamp
  (
    input logic [15:0] v,
    input logic [15:0] lo,
    input logic [15:0] hi
  );
    logic [15:0] res;
    res = v;
    if (v < lo)
      res = lo;
    if (v > hi)
      res = hi;
    return res;
  endfunction : sebas_clamp

  // 10 ms settings expressed in ms
  function automatic logic [15:0] sebas_x10(input logic [15:0] v);
    logic [19:0] p;
    p = 20'(v) * 20'(`SEBAS_UNIT_10MS);
    return p[15:0];
  endfunction : sebas_x10

  // effective brake speed level, never above the motor's top speed
  function automatic logic [15:0] sebas_eff_level
  (
    input logic [15:0] level,
    input logic [15:0] top
  );
    return (level > top) ? top : level;
  endfunction : sebas_eff_level

  // status word: alarm, brake, energize, then the one-hot state
  function automatic logic [31:0] sebas_status_word
  (
    input sebas_pkg::sebas_state_type st,
    input logic                       energize,
    input logic                       brake,
    input logic                       alarm
  );
    return {24'h000000, alarm, brake, energize, st};
  endfunction : sebas_status_word

  //--------------------------------------------------------------------
  // next state
  //--------------------------------------------------------------------
  // decode of the current cycle
  logic        tick;
  logic        want_on;
  logic        rotating;
  logic        clr_alarm;
  logic [15:0] eff_lvl;
  logic [`SEBAS_EV_W-1:0] ev;
  logic [`SEBAS_EV_W-1:0] clr_bits;
  logic        acc;

  always_comb
  begin
    next_r = r;
    ev = '0;
    clr_bits = '0;
    // a write commits at the edge where waitrequest is sampled low
    acc = write && !r.waitrequest;
    // 1 ms tick from the system clock
    tick = (r.tick_cnt == 18'(`SEBAS_TICK_CYC - 1)); // RULE19
    next_r.tick_cnt = tick ? 18'h00000 : r.tick_cnt + 18'h00001;
    // effective enable: source select overrides the input
    want_on = r.enable_source_select | ~servo_enable_n; // RULE14 RULE15
    // clamp threshold to the maximum motor speed
    eff_lvl = sebas_eff_level(r.running_brake_speed_level,
                              r.max_speed); // RULE7
    rotating = (motor_speed >= eff_lvl); // RULE3
    // alarm latch: detect sets, clear input or panel clears
    clr_alarm = ~alarm_clear_in | panel_clear | // RULE11 RULE13
                (acc && write && address == `SEBAS_REG_CTRL &&
                 writedata[`SEBAS_CTRL_PANEL_CLR]);
    if (clr_alarm)
      next_r.alarm = 1'b0;
    if (alarm_detect)
      next_r.alarm = 1'b1; // set wins over clear
    if (alarm_detect && !r.alarm)
      ev[`SEBAS_EV_ALARM] = 1'b1;
    // delay and timeout counters run down on the tick
    if (tick && r.ms_cnt != 16'h0000)
      next_r.ms_cnt = r.ms_cnt - 16'h0001; // RULE19
    if (tick && r.stop_cnt != 16'h0000)
      next_r.stop_cnt = r.stop_cnt - 16'h0001;

    // sequencer
    unique case (r.st)
      // idle: brake applied, motor not driven
      sebas_pkg::SEBAS_OFF:
      begin
        next_r.motor_energize = 1'b0;
        next_r.brake_interlock_out = 1'b1; // RULE17
        if (want_on && !next_r.alarm)
        begin
          next_r.st = sebas_pkg::SEBAS_ON_WAIT;
          next_r.ms_cnt = r.servo_on_delay; // RULE1
        end
      end
      // on-delay running; dropping enable or an alarm aborts
      sebas_pkg::SEBAS_ON_WAIT:
      begin
        if (!want_on || next_r.alarm)
          next_r.st = sebas_pkg::SEBAS_OFF; // RULE18
        else if (r.ms_cnt == 16'h0000)
        begin
          next_r.st = sebas_pkg::SEBAS_RUN;
          next_r.motor_energize = 1'b1; // RULE1
          next_r.brake_interlock_out = 1'b0; // RULE17
          ev[`SEBAS_EV_ENERGIZE] = 1'b1;
        end
      end
      // servo on; an off request leaves, the speed picks the path
      sebas_pkg::SEBAS_RUN:
      begin
        if (next_r.alarm || !want_on) // RULE18
        begin
          ev[`SEBAS_EV_OFF] = 1'b1;
          if (next_r.alarm)
            next_r.motor_energize = 1'b0; // RULE9
          if (rotating)
          begin
            // servo off during rotation, by enable or alarm
            next_r.st = sebas_pkg::SEBAS_STOP_RUN; // RULE8
            next_r.motor_energize = 1'b0;
            next_r.stop_cnt = sebas_x10(r.running_brake_timeout); // RULE4
          end
          else
          begin
            next_r.st = sebas_pkg::SEBAS_HOLD;
            next_r.brake_interlock_out = 1'b1; // RULE2
            ev[`SEBAS_EV_BRAKE] = 1'b1;
            next_r.ms_cnt = sebas_x10(r.brake_to_off_delay); // RULE2
          end
        end
      end
      sebas_pkg::SEBAS_STOP_RUN:
      begin
        // brake on speed drop or timeout, whichever first
        if (!rotating || r.stop_cnt == 16'h0000) // RULE5 RULE6
        begin
          next_r.brake_interlock_out = 1'b1;
          ev[`SEBAS_EV_BRAKE] = 1'b1;
          next_r.st = sebas_pkg::SEBAS_OFF;
        end
      end
      sebas_pkg::SEBAS_HOLD:
      begin
        // drive held until off-delay ends; alarm cuts at once
        if (next_r.alarm)
          next_r.motor_energize = 1'b0; // RULE9
        if (r.ms_cnt == 16'h0000 || next_r.alarm)
        begin
          next_r.motor_energize = 1'b0;
          next_r.st = sebas_pkg::SEBAS_OFF;
        end
      end
    endcase
    next_r.alarm_out = next_r.alarm; // RULE10

    // register bus: waitrequest drops for one cycle once a write is
    // seen, or on the cycle after a read, when its data stand
    next_r.rd_pend = read && !r.rd_pend;
    next_r.waitrequest = 1'b1;
    if (write && r.waitrequest)
      next_r.waitrequest = 1'b0;
    if (read && !r.rd_pend)
      next_r.waitrequest = 1'b0;

    // settings writes; delays, speed level and timeout clamped into their ranges, max speed taken as written
    if (acc)
    begin
      unique case (address)
        `SEBAS_REG_ON_DLY:
          next_r.servo_on_delay = sebas_clamp(writedata[15:0],
            16'h0000, `SEBAS_ON_DLY_MAX);
        `SEBAS_REG_OFF_DLY:
          next_r.brake_to_off_delay = sebas_clamp(writedata[15:0],
            16'h0000, `SEBAS_OFF_DLY_MAX);
        `SEBAS_REG_SPD_LVL:
          next_r.running_brake_speed_level = sebas_clamp(
            writedata[15:0], `SEBAS_SPD_LVL_MIN, `SEBAS_SPD_LVL_MAX);
        `SEBAS_REG_TMO:
          next_r.running_brake_timeout = sebas_clamp(writedata[15:0],
            `SEBAS_TMO_MIN, `SEBAS_TMO_MAX);
        `SEBAS_REG_CTRL:
          next_r.enable_source_select = writedata[`SEBAS_CTRL_SRC];
        `SEBAS_REG_IRQ_EN:
          next_r.irq_en = writedata[`SEBAS_EV_W-1:0];
        `SEBAS_REG_IRQ_CLR:
          clr_bits = writedata[`SEBAS_EV_W-1:0];
        `SEBAS_REG_MAX_SPEED:
          next_r.max_speed = writedata[15:0];
        default:
          next_r.max_speed = r.max_speed; // unmapped: ignored
      endcase
    end

    // readback, loaded on the first cycle of a read
    next_r.readdata = 32'h00000000;
    if (read && !r.rd_pend)
    begin
      unique case (address)
        `SEBAS_REG_ON_DLY:    next_r.readdata = {16'h0000, r.servo_on_delay};
        `SEBAS_REG_OFF_DLY:
          next_r.readdata = {16'h0000, r.brake_to_off_delay};
        `SEBAS_REG_SPD_LVL:
          next_r.readdata = {16'h0000, r.running_brake_speed_level};
        `SEBAS_REG_TMO:
          next_r.readdata = {16'h0000, r.running_brake_timeout};
        `SEBAS_REG_CTRL:
          next_r.readdata = {31'h00000000, r.enable_source_select};
        `SEBAS_REG_STATUS:
          next_r.readdata = sebas_status_word(r.st, r.motor_energize,
                                              r.brake_interlock_out, r.alarm);
        `SEBAS_REG_IRQ_STAT:
          next_r.readdata = {28'h0000000, r.irq_stat};
        `SEBAS_REG_IRQ_EN:
          next_r.readdata = {28'h0000000, r.irq_en};
        `SEBAS_REG_MAX_SPEED:
          next_r.readdata = {16'h0000, r.max_speed};
        default:
          next_r.readdata = 32'h00000000;
      endcase
    end

    // sticky events, set wins over clear
    next_r.irq_stat = (r.irq_stat & ~clr_bits) | ev;
    next_r.irq = |(next_r.irq_stat & next_r.irq_en);
  end

  //--------------------------------------------------------------------
  // registers; power-on reset clears the alarm
  //--------------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      r <= '0;
      r.st <= sebas_pkg::SEBAS_OFF;
      r.servo_on_delay <= `SEBAS_ON_DLY_RST;
      r.brake_to_off_delay <= `SEBAS_OFF_DLY_RST;
      r.running_brake_speed_level <= `SEBAS_SPD_LVL_RST;
      r.running_brake_timeout <= `SEBAS_TMO_RST;
      r.max_speed <= `SEBAS_MAX_SPEED_RST;
      r.brake_interlock_out <= 1'b1; // RULE17
      r.alarm <= 1'b0; // RULE12
      r.waitrequest <= 1'b1;
    end
    else
      r <= next_r;
  end

  // outputs straight from flip-flops
  assign readdata = r.readdata;
  assign waitrequest = r.waitrequest;
  assign motor_energize = r.motor_energize;
  assign brake_interlock_out = r.brake_interlock_out;
  assign alarm_out = r.alarm_out;
  assign irq = r.irq;

endmodule : sebas_seq

// ===== dv/sebas_seq_sva.sv
// Purpose: port checker for sebas_seq
// Assumes: alarm, stop and clear act on the next edge
// Notes:   source and irq enable mirrored from bus writes
`timescale 1ns/1ns
module sebas_seq_sva
(
  // clock, reset, bus
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [3:0]  address,
  input wire logic        write,
  input wire logic [31:0] writedata,
  input wire logic        waitrequest,
  // drive side
  input wire logic        servo_enable_n,
  input wire logic        alarm_detect,
  input wire logic [15:0] motor_speed,
  input wire logic        alarm_clear_in,
  input wire logic        panel_clear,
  input wire logic        motor_energize,
  input wire logic        brake_interlock_out,
  input wire logic        alarm_out,
  input wire logic        irq
);
  logic src;
  logic alarm_irq_en;
  wire  ctl_wr  = write && address == 4'h4;
  wire  pclr    = panel_clear || (ctl_wr && writedata[1]);
  wire  off_req = !src && servo_enable_n && !ctl_wr;
  // mirror of enable source and alarm irq enable
  always_ff @(posedge clk or posedge reset)
    if (reset)
    begin
      src    <= 1'b0;
      alarm_irq_en <= 1'b0;
    end
    else if (write && !waitrequest)
    begin
      if (address == 4'h4)
        src <= writedata[0];
      if (address == 4'h7)
        alarm_irq_en <= writedata[0];
    end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // motor driven with brake released
  sequence s_run;
    motor_energize && !brake_interlock_out;
  endsequence
  a_alarm_cut: assert property (alarm_detect
    |=> alarm_out && !motor_energize) else $error("alarm kept drive");
  a_clear_hold: assert property (alarm_out && alarm_clear_in
    && !pclr |=> alarm_out) else $error("alarm dropped unasked");
  a_clear_low: assert property (alarm_out && !alarm_clear_in
    && !alarm_detect |=> !alarm_out) else $error("clear input ignored");
  a_panel_clear: assert property (alarm_out && panel_clear
    && !alarm_detect |=> !alarm_out) else $error("panel clear ignored");
  a_stop_still: assert property (s_run ##0 (off_req
    && !alarm_detect && motor_speed < 16'h000a) |=> brake_interlock_out)
    else $error("no brake on standstill stop");
  a_stop_spin: assert property (s_run ##0 ((off_req
    || alarm_detect) && motor_speed >= 16'h0064)
    |=> !motor_energize && !brake_interlock_out)
    else $error("wrong outputs on spinning stop");
  a_source_hold: assert property (s_run ##0 (src
    && !ctl_wr && !alarm_detect) |=> s_run) else $error("source lost run");
  a_irq_alarm: assert property ($rose(alarm_out) && alarm_irq_en
    |-> ##[0:2] irq) else $error("alarm irq missing");
endmodule : sebas_seq_sva

// ===== dv/sebas_motor.sv
// Purpose: motor and load model beside sebas_seq
// Assumes: speed follows target while driven and released
// Notes:   coasts down 4 rpm a cycle otherwise
`timescale 1ns/1ns
module sebas_motor
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // drive, brake and load
  input  wire logic        motor_energize,
  input  wire logic        brake_interlock_out,
  input  wire logic [15:0] target_speed,
  output logic      [15:0] motor_speed
);
  // drive spins the shaft, friction slows it
  always_ff @(posedge clk or posedge reset)
    if (reset)
      motor_speed <= 16'h0000;
    else if (motor_energize && !brake_interlock_out)
      motor_speed <= target_speed;
    else if (motor_speed > 16'h0004)
      motor_speed <= motor_speed - 16'h0004;
    else
      motor_speed <= 16'h0000;
endmodule : sebas_motor

// ===== dv/tb_sebas_seq.sv
// Purpose: self-checking bench for sebas_seq
// Assumes: delays stay at zero, so the 1 ms tick is never awaited
// Notes:   sebas_motor stands in for motor and load
`timescale 1ns/1ns
module tb_sebas_seq;
  logic        clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0;
  logic        servo_enable_n = 1'b1, alarm_detect = 1'b0;
  logic        alarm_clear_in = 1'b1, panel_clear = 1'b0;
  logic        waitrequest, motor_energize, brake_interlock_out;
  logic        alarm_out, irq;
  logic [3:0]  address = 4'h0;
  logic [15:0] motor_speed, target_speed = 16'h0;
  logic [31:0] writedata = 32'h0, readdata, q;
  int          mismatches = 0, checks = 0;

  sebas_seq sebas_seq_i
  (
    .clk(clk), .reset(reset), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .servo_enable_n(servo_enable_n),
    .alarm_detect(alarm_detect), .motor_speed(motor_speed),
    .alarm_clear_in(alarm_clear_in), .panel_clear(panel_clear),
    .motor_energize(motor_energize),
    .brake_interlock_out(brake_interlock_out), .alarm_out(alarm_out),
    .irq(irq)
  );
  sebas_motor sebas_motor_i
  (
    .clk(clk), .reset(reset), .motor_energize(motor_energize),
    .brake_interlock_out(brake_interlock_out),
    .target_speed(target_speed), .motor_speed(motor_speed)
  );

  // 250 MHz clock
  initial forever #2 clk = ~clk;

  task automatic tally_and_finish(input logic hung);
    if (hung)
      mismatches++;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string s, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", s, e, g);
    end
  endtask : chk

  // one transfer, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    address   <= a;
    writedata <= d;
    write     <= w;
    read      <= !w;
    repeat (50)
    begin
      @(posedge clk);
      if (waitrequest === 1'b0)
        break;
    end
    q = readdata;
    write <= 1'b0;
    read  <= 1'b0;
    if (waitrequest !== 1'b0)
      tally_and_finish(1'b1);
  endtask : bus

  // bounded wait for energize (sel 0) or brake (sel 1)
  task automatic wait_out(input logic sel, input logic v);
    int n;
    n = 0;
    while ((sel ? brake_interlock_out : motor_energize) !== v)
    begin
      @(posedge clk);
      n++;
      if (n > 400)
        tally_and_finish(1'b1);
    end
  endtask : wait_out

  task automatic spin_up();
    target_speed   <= 16'h01f4;
    servo_enable_n <= 1'b0;
    wait_out(1'b0, 1'b1);
    repeat (4) @(posedge clk);
  endtask : spin_up

  task automatic t_defaults();
    logic [3:0]  ra [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h9, 4'hf};
    logic [31:0] rv [6] = '{32'h0, 32'h0, 32'h64, 32'h32, 32'hbb8, 32'h0};
    logic [31:0] wv [4] = '{32'hbb8, 32'h258, 32'h5, 32'hc8};
    logic [31:0] cv [4] = '{32'h7d0, 32'h1f4, 32'ha, 32'h64};
    chk("brake", 32'h1, brake_interlock_out);
    chk("alarm", 32'h0, alarm_out);
    for (int i = 0; i < 6; i++)
    begin
      bus(1'b0, ra[i], 32'h0);
      chk("reg", rv[i], q);
    end
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, ra[i], wv[i]);
      bus(1'b0, ra[i], 32'h0);
      chk("clamp", cv[i], q);
      bus(1'b1, ra[i], rv[i]);
    end
    $display("test defaults done");
  endtask : t_defaults

  task automatic t_still();
    servo_enable_n <= 1'b0;
    wait_out(1'b0, 1'b1);
    chk("released", 32'h0, brake_interlock_out);
    bus(1'b0, 4'h5, 32'h0);
    chk("status", 32'h24, q);
    servo_enable_n <= 1'b1;
    wait_out(1'b1, 1'b1);
    wait_out(1'b0, 1'b0);
    $display("test still done");
  endtask : t_still

  task automatic t_spin(input logic [15:0] lvl);
    spin_up();
    servo_enable_n <= 1'b1;
    wait_out(1'b0, 1'b0);
    chk("coast", 32'h0, brake_interlock_out);
    wait_out(1'b1, 1'b1);
    chk("below", 32'h1, motor_speed < lvl);
    chk("near", 32'h1, motor_speed + 16'h000c >= lvl);
    $display("test spin done");
  endtask : t_spin

  task automatic t_alarm();
    bus(1'b1, 4'h7, 32'h1);
    spin_up();
    alarm_detect <= 1'b1;
    wait_out(1'b0, 1'b0);
    chk("alarm", 32'h1, alarm_out);
    chk("coast", 32'h0, brake_interlock_out);
    alarm_detect <= 1'b0;
    repeat (4) @(posedge clk);
    chk("irq", 32'h1, irq);
    chk("clear high", 32'h1, alarm_out);
    chk("no drive", 32'h0, motor_energize);
    servo_enable_n <= 1'b1;
    alarm_clear_in <= 1'b0;
    repeat (3) @(posedge clk);
    chk("clear low", 32'h0, alarm_out);
    alarm_clear_in <= 1'b1;
    bus(1'b1, 4'h8, 32'hf);
    repeat (2) @(posedge clk);
    chk("irq clr", 32'h0, irq);
    bus(1'b1, 4'h7, 32'h0);
    alarm_detect <= 1'b1;
    @(posedge clk);
    alarm_detect <= 1'b0;
    repeat (3) @(posedge clk);
    chk("irq mask", 32'h0, irq);
    bus(1'b0, 4'h6, 32'h0);
    chk("irq stat", 32'h1, {31'h0, q[0]});
    panel_clear <= 1'b1;
    @(posedge clk);
    panel_clear <= 1'b0;
    repeat (2) @(posedge clk);
    chk("panel", 32'h0, alarm_out);
    $display("test alarm done");
  endtask : t_alarm

  task automatic t_source();
    target_speed <= 16'h0000;
    bus(1'b1, 4'h4, 32'h1);
    wait_out(1'b0, 1'b1);
    bus(1'b1, 4'h4, 32'h0);
    wait_out(1'b1, 1'b1);
    $display("test source done");
  endtask : t_source

  // reset, then scenarios in turn
  initial
  begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    t_defaults();
    t_still();
    t_spin(16'h0064);
    bus(1'b1, 4'h9, 32'h32);
    t_spin(16'h0032);
    bus(1'b1, 4'h9, 32'hbb8);
    t_alarm();
    t_source();
    tally_and_finish(1'b0);
  end
endmodule : tb_sebas_seq

bind sebas_seq sebas_seq_sva sebas_seq_sva_i
(
  .clk(clk), .reset(reset), .address(address), .write(write),
  .writedata(writedata), .waitrequest(waitrequest),
  .servo_enable_n(servo_enable_n), .alarm_detect(alarm_detect),
  .motor_speed(motor_speed), .alarm_clear_in(alarm_clear_in),
  .panel_clear(panel_clear), .motor_energize(motor_energize),
  .brake_interlock_out(brake_interlock_out), .alarm_out(alarm_out),
  .irq(irq)
);
